// file: hw/spi_ctrl_pkg.sv
// Shared constants and types for the serial controller
package spi_ctrl_pkg;
	localparam int          DATA_W   = 8;
	localparam int          CNT_W    = 3;
	localparam logic [2:0]  CNT_LAST = 3'h7;
	localparam logic [2:0]  CNT_ZERO = 3'h0;
	localparam logic [2:0]  CNT_ONE  = 3'h1;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam int          MSB      = DATA_W - 1;

	typedef enum logic [2:0] {
		L_IDLE  = 3'b001,
		L_SHIFT = 3'b010,
		L_GAP   = 3'b100
	} link_state_type;
endpackage

// file: hw/spi_link_engine.sv
// Serial shift engine running on the link clock
`timescale 1ns/1ps
module spi_link_engine
	import spi_ctrl_pkg::*;
(
	input  wire logic              lclk_i,
	input  wire logic              rstn_i,
	input  wire logic              start_tgl_i,
	input  wire logic [DATA_W-1:0] tx_byte_i,
	input  wire logic              en_i,
	input  wire logic              master_i,
	input  wire logic              receive_only_bit_i,
	input  wire logic              sel_n_i,
	input  wire logic              sdi_i,
	output logic                   sdo_o,
	output logic                   sdo_oe_o,
	output logic                   done_tgl_o,
	output logic [DATA_W-1:0]      rx_byte_o,
	output logic                   active_o
);

	typedef struct packed {
		logic               en_s1;
		logic               en_s2;
		logic               ms_s1;
		logic               ms_s2;
		logic               ro_s1;
		logic               ro_s2;
		logic               st_s1;
		logic               st_s2;
		logic               st_s3;
		logic               req;
		link_state_type     st;
		logic [CNT_W-1:0]   cnt;
		logic [DATA_W-1:0]  sh;
		logic [DATA_W-1:0]  rx;
		logic               done;
		logic               act;
		logic               sdo;
		logic               oe;
	} link_regs_type;

	link_regs_type q;
	link_regs_type d;
	logic          rst_s1_q;
	logic          rst_s2_q;
	logic          go;

	////////////////////////////////////////////////////////////////////////
	// Local reset release, asserted asynchronously
	always_ff @(posedge lclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d       = q;
		d.en_s1 = en_i;
		d.en_s2 = q.en_s1;
		d.ms_s1 = master_i;
		d.ms_s2 = q.ms_s1;
		d.ro_s1 = receive_only_bit_i;
		d.ro_s2 = q.ro_s1;
		d.st_s1 = start_tgl_i;
		d.st_s2 = q.st_s1;
		d.st_s3 = q.st_s2;
		// Keep a start request so a toggle seen mid-byte is not lost
		if (q.st_s2 != q.st_s3) begin
			d.req = 1'b1;
		end
		// Enable is looked at only between bytes, so a byte always ends
		go = q.en_s2 && (q.ms_s2 ? (q.ro_s2 || q.req) : !sel_n_i);
		case (q.st)
			L_IDLE: begin
				if (go) begin
					d.st  = L_SHIFT;
					d.req = 1'b0;
					d.sh  = tx_byte_i;
					d.cnt = CNT_ZERO;
					d.act = 1'b1;
					d.oe  = !q.ro_s2;
					d.sdo = tx_byte_i[MSB];
				end
			end
			L_SHIFT: begin
				d.sh  = {q.sh[MSB-1:0], sdi_i};
				d.cnt = q.cnt + CNT_ONE;
				d.sdo = q.sh[MSB-1];
				if (q.cnt == CNT_LAST) begin
					d.st   = L_GAP;
					d.rx   = {q.sh[MSB-1:0], sdi_i};
					d.done = !q.done;
					d.act  = 1'b0;
					d.oe   = 1'b0;
				end
			end
			L_GAP: begin
				// With L_IDLE after it, two idle link cycles between bytes
				d.st = L_IDLE;
			end
			default: begin
				d.st  = L_IDLE;
				d.act = 1'b0;
				d.oe  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge lclk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			q <= '{st: L_IDLE, cnt: CNT_ZERO, sh: BYTE_RST, rx: BYTE_RST,
			       default: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign sdo_o      = q.sdo;
	assign sdo_oe_o   = q.oe;
	assign done_tgl_o = q.done;
	assign rx_byte_o  = q.rx;
	assign active_o   = q.act;
endmodule

// file: hw/spi_ctrl_top.sv
// Serial controller: enable, status flags and DMA request logic
`timescale 1ns/1ps
module spi_ctrl_top
	import spi_ctrl_pkg::*;
(
	input  wire logic              CLK_SYS_I,
	input  wire logic              RSTN_I,
	input  wire logic              LINK_CLK_I,
	input  wire logic              SPI_ENABLE_BIT_I,
	input  wire logic              MASTER_SELECT_BIT_I,
	input  wire logic              BIDIR_MODE_BIT_I,
	input  wire logic              BIDIR_OUTPUT_ENABLE_I,
	input  wire logic              RECEIVE_ONLY_BIT_I,
	input  wire logic              TX_DMA_EN_I,
	input  wire logic              RX_DMA_EN_I,
	input  wire logic              DR_WR_I,
	input  wire logic [DATA_W-1:0] DR_WDATA_I,
	input  wire logic              DR_RD_I,
	input  wire logic              OVR_CLR_I,
	input  wire logic              TX_DMA_ACK_I,
	input  wire logic [DATA_W-1:0] TX_DMA_DATA_I,
	input  wire logic              RX_DMA_ACK_I,
	input  wire logic              SEL_N_I,
	input  wire logic              SDI_I,
	output logic                   SDO_O,
	output logic                   SDO_OE_O,
	output logic                   SPI_ENABLED_O,
	output logic                   TX_EMPTY_FLAG_O,
	output logic                   RX_NOT_EMPTY_FLAG_O,
	output logic                   BUSY_FLAG_O,
	output logic                   OVERRUN_FLAG_O,
	output logic [DATA_W-1:0]      RX_DATA_O,
	output logic                   TX_DMA_REQ_O,
	output logic                   RX_DMA_REQ_O
);

	typedef struct packed {
		logic              en;
		logic              tx_empty_flag;
		logic [DATA_W-1:0] tx_buf;
		logic [DATA_W-1:0] tx_byte;
		logic              start_tgl;
		logic              pend;
		logic              rx_not_empty_flag;
		logic [DATA_W-1:0] rx_buf;
		logic              overrun_flag;
		logic              busy;
		logic              txreq;
		logic              rxreq;
		logic              dn_s1;
		logic              dn_s2;
		logic              dn_s3;
		logic              ac_s1;
		logic              ac_s2;
	} sys_regs_type;

	sys_regs_type      q;
	sys_regs_type      d;
	logic              rst_s1_q;
	logic              rst_s2_q;
	logic              link_done;
	logic              link_act;
	logic [DATA_W-1:0] link_rx;
	logic              rx_mode;
	logic              wr;
	logic              rd;
	logic              done;
	logic              busy_off;
	logic [DATA_W-1:0] wdata;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link side; tx byte is held while a byte is pending so it is stable
	// when sampled. In slave role a new hand-off may land as the master
	// starts a byte; software must load data before selecting.
	spi_link_engine u_link (
		.lclk_i      (LINK_CLK_I),
		.rstn_i      (RSTN_I),
		.start_tgl_i (q.start_tgl),
		.tx_byte_i   (q.tx_byte),
		.en_i        (q.en),
		.master_i    (MASTER_SELECT_BIT_I),
		.receive_only_bit_i    (rx_mode),
		.sel_n_i     (SEL_N_I),
		.sdi_i       (SDI_I),
		.sdo_o       (SDO_O),
		.sdo_oe_o    (SDO_OE_O),
		.done_tgl_o  (link_done),
		.rx_byte_o   (link_rx),
		.active_o    (link_act)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d        = q;
		rx_mode  = (!BIDIR_MODE_BIT_I && RECEIVE_ONLY_BIT_I) ||
		           (BIDIR_MODE_BIT_I && !BIDIR_OUTPUT_ENABLE_I);
		wr       = DR_WR_I || TX_DMA_ACK_I;
		wdata    = TX_DMA_ACK_I ? TX_DMA_DATA_I : DR_WDATA_I;
		rd       = DR_RD_I || RX_DMA_ACK_I;
		busy_off = MASTER_SELECT_BIT_I && BIDIR_MODE_BIT_I &&
		           !BIDIR_OUTPUT_ENABLE_I;
		d.dn_s1  = link_done;
		d.dn_s2  = q.dn_s1;
		d.dn_s3  = q.dn_s2;
		d.ac_s1  = link_act;
		d.ac_s2  = q.ac_s1;
		done     = q.dn_s2 != q.dn_s3;

		// Slave receive keeps running until the byte on the wire ends
		if (SPI_ENABLE_BIT_I) begin
			d.en = 1'b1;
		end else if (!MASTER_SELECT_BIT_I && rx_mode && q.ac_s2) begin
			d.en = q.en;
		end else begin
			d.en = 1'b0;
		end

		// Hand the buffered byte to the link once the last one is done
		if (q.en && !q.tx_empty_flag && !q.pend) begin
			d.tx_byte   = q.tx_buf;
			d.start_tgl = !q.start_tgl;
			d.tx_empty_flag       = 1'b1;
			d.pend      = 1'b1;
		end
		if (wr) begin
			d.tx_buf = wdata;
			d.tx_empty_flag    = 1'b0;
		end

		if (rd) begin
			d.rx_not_empty_flag = 1'b0;
		end
		if (OVR_CLR_I) begin
			d.overrun_flag = 1'b0;
		end
		// A byte landing on a full buffer is dropped, old data kept
		if (done) begin
			d.pend = 1'b0;
			if (q.rx_not_empty_flag && !rd) begin
				d.overrun_flag = 1'b1;
			end else begin
				d.rx_buf = link_rx;
				d.rx_not_empty_flag   = 1'b1;
			end
		end
		if (!d.en) begin
			d.pend = 1'b0;
		end

		// Filled buffer drives busy one edge later: two clocks after write
		// Master receive-only streams on its own, so busy stands while enabled; master bidirectional receive keeps busy low
		d.busy  = d.en && !busy_off &&
		          (q.ac_s2 ||
		           (MASTER_SELECT_BIT_I &&
		            (q.pend || !q.tx_empty_flag || rx_mode)));
		// Level requests follow the flags, so an access drops them
		d.txreq = TX_DMA_EN_I && d.en && d.tx_empty_flag;
		d.rxreq = RX_DMA_EN_I && d.rx_not_empty_flag;
	end

	always_ff @(posedge CLK_SYS_I or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			q <= '{tx_empty_flag: 1'b1, tx_buf: BYTE_RST, tx_byte: BYTE_RST,
			       rx_buf: BYTE_RST, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign SPI_ENABLED_O       = q.en;
	assign TX_EMPTY_FLAG_O     = q.tx_empty_flag;
	assign RX_NOT_EMPTY_FLAG_O = q.rx_not_empty_flag;
	assign BUSY_FLAG_O         = q.busy;
	assign OVERRUN_FLAG_O      = q.overrun_flag;
	assign RX_DATA_O           = q.rx_buf;
	assign TX_DMA_REQ_O        = q.txreq;
	assign RX_DMA_REQ_O        = q.rxreq;
endmodule

// file: verification/spi_ctrl_checker_assertions.sv
// Timing properties of the serial controller top ports
`timescale 1ns/1ps
module spi_ctrl_checker (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic SPI_ENABLE_BIT_I,
	input wire logic MASTER_SELECT_BIT_I,
	input wire logic BIDIR_MODE_BIT_I,
	input wire logic BIDIR_OUTPUT_ENABLE_I,
	input wire logic RECEIVE_ONLY_BIT_I,
	input wire logic TX_DMA_EN_I,
	input wire logic RX_DMA_EN_I,
	input wire logic DR_WR_I,
	input wire logic DR_RD_I,
	input wire logic OVR_CLR_I,
	input wire logic TX_DMA_ACK_I,
	input wire logic RX_DMA_ACK_I,
	input wire logic SPI_ENABLED_O,
	input wire logic TX_EMPTY_FLAG_O,
	input wire logic RX_NOT_EMPTY_FLAG_O,
	input wire logic BUSY_FLAG_O,
	input wire logic OVERRUN_FLAG_O,
	input wire logic TX_DMA_REQ_O,
	input wire logic RX_DMA_REQ_O
);
	wire wr_any = DR_WR_I | TX_DMA_ACK_I;
	wire mtx = MASTER_SELECT_BIT_I & ~BIDIR_MODE_BIT_I & ~RECEIVE_ONLY_BIT_I;
	wire brx = MASTER_SELECT_BIT_I & BIDIR_MODE_BIT_I & ~BIDIR_OUTPUT_ENABLE_I;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
////////////////////////////////////////////////////////////////////////////
	a_busy_late: assert property (wr_any && mtx && SPI_ENABLED_O &&
		TX_EMPTY_FLAG_O && !BUSY_FLAG_O |=> !BUSY_FLAG_O ##1 BUSY_FLAG_O)
		else $error("busy not set two clocks after write");
	a_tx_clear: assert property (wr_any |=> !TX_EMPTY_FLAG_O)
		else $error("transmit empty not cleared by write");
	a_rx_clear: assert property (DR_RD_I || RX_DMA_ACK_I |=>
		!RX_NOT_EMPTY_FLAG_O) else $error("receive flag not cleared");
	a_tx_gate: assert property (TX_DMA_REQ_O |->
		$past(TX_DMA_EN_I) && TX_EMPTY_FLAG_O && SPI_ENABLED_O)
		else $error("transmit request without cause");
	a_rx_gate: assert property (RX_DMA_REQ_O |->
		$past(RX_DMA_EN_I) && RX_NOT_EMPTY_FLAG_O)
		else $error("receive request without cause");
	a_txreq_drop: assert property (TX_DMA_ACK_I |->
		##[1:2] !TX_DMA_REQ_O) else $error("transmit request stuck");
	a_rxreq_drop: assert property (RX_DMA_ACK_I |->
		##[1:2] !RX_DMA_REQ_O) else $error("receive request stuck");
	a_ovr_sticky: assert property (OVERRUN_FLAG_O && !OVR_CLR_I |=>
		OVERRUN_FLAG_O) else $error("overrun lost");
	a_bidir_idle: assert property (brx [*4] |-> !BUSY_FLAG_O)
		else $error("busy set in bidirectional receive");
	a_stop_fast: assert property (!SPI_ENABLE_BIT_I && MASTER_SELECT_BIT_I
		|=> !SPI_ENABLED_O) else $error("master not stopped");
	a_busy_off: assert property (!SPI_ENABLED_O [*4] |-> !BUSY_FLAG_O)
		else $error("busy while disabled");
	c_tx: cover property (wr_any && mtx);
	c_rx_dma: cover property (RX_DMA_ACK_I);
	c_slave_stop: cover property ($fell(SPI_ENABLED_O) && !MASTER_SELECT_BIT_I);
endmodule
bind spi_ctrl_top spi_ctrl_checker u_chk (.*);

// file: verification/dma_ctrl_model.sv
// DMA controller model serving transmit and receive requests
`timescale 1ns/1ps
module dma_ctrl_model (
	input  wire logic  clk_i,
	input  wire logic  tx_req_i,
	input  wire logic  rx_req_i,
	input  wire logic  slow_i,
	output logic       tx_ack_o = 1'b0,
	output logic       rx_ack_o = 1'b0,
	output logic [7:0] tx_data_o,
	output logic [7:0] tx_cnt_o = 8'h00,
	output logic [7:0] rx_cnt_o = 8'h00
);
	logic [3:0] gap_q = 4'h0;
	// Requests are levels: a gap after each ack avoids a double take
	always @(negedge clk_i) begin
		tx_ack_o <= 1'b0;
		rx_ack_o <= 1'b0;
		if (gap_q < 4'hF)
			gap_q <= gap_q + 4'h1;
		if (gap_q >= (slow_i ? 4'h8 : 4'h3)) begin
			if (tx_req_i) begin
				tx_ack_o <= 1'b1;
				tx_cnt_o <= tx_cnt_o + 8'h01;
				gap_q <= 4'h0;
			end else if (rx_req_i) begin
				rx_ack_o <= 1'b1;
				rx_cnt_o <= rx_cnt_o + 8'h01;
				gap_q <= 4'h0;
			end
		end
	end
	// Junk outside an ack, so a stale byte is never taken
	assign tx_data_o = tx_ack_o ? tx_cnt_o + 8'hA0 : ~(tx_cnt_o + 8'hA0);
endmodule

// file: verification/spi_shutdown_and_dma_requests_bench.sv
// Self-checking bench for serial shutdown and DMA requests
`timescale 1ns/1ps
module spi_shutdown_and_dma_requests_bench
	import spi_ctrl_pkg::*;
;
	logic clk = 0, lclk = 0, rst_n = 0, sdi = 0, slow = 0, sel_n = 1;
	logic en = 0, mst = 0, bidir_mode_bit = 0, bidir_output_enable = 0, ronly = 0, txen = 0;
	logic rxen = 0, wr = 0, rd = 0, oclr = 0, txack, rxack, sdo, sdoe;
	logic ena, tx_empty_flag, rx_not_empty_flag, busy, overrun_flag, txrq, rxrq;
	logic [DATA_W-1:0] wd = 8'hC3, txd, rxd, ntx, nrx;
	int num_errors = 0, n_tests = 0, k;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
	num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
`define WAIT(s, v) begin k = 0; \
	while ((s) !== (v) && k < 2000) begin @(negedge clk); k++; end \
	if (k >= 2000) num_errors++; end
////////////////////////////////////////////////////////////////////////////
	always #12.5 clk = ~clk;
	// Offset keeps link edges off the stimulus edges
	initial #3 forever #80 lclk = ~lclk;
	// Remote side echoes a driven line, else toggles
	always @(negedge lclk) sdi <= sdoe ? sdo : ~sdi;
	spi_ctrl_top u_dut (.CLK_SYS_I(clk), .RSTN_I(rst_n), .LINK_CLK_I(lclk),
		.SPI_ENABLE_BIT_I(en), .MASTER_SELECT_BIT_I(mst),
		.BIDIR_MODE_BIT_I(bidir_mode_bit), .BIDIR_OUTPUT_ENABLE_I(bidir_output_enable),
		.RECEIVE_ONLY_BIT_I(ronly), .TX_DMA_EN_I(txen), .RX_DMA_EN_I(rxen),
		.DR_WR_I(wr), .DR_WDATA_I(wd), .DR_RD_I(rd), .OVR_CLR_I(oclr),
		.TX_DMA_ACK_I(txack), .TX_DMA_DATA_I(txd), .RX_DMA_ACK_I(rxack),
		.SEL_N_I(sel_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdoe),
		.SPI_ENABLED_O(ena), .TX_EMPTY_FLAG_O(tx_empty_flag), .RX_DATA_O(rxd),
		.RX_NOT_EMPTY_FLAG_O(rx_not_empty_flag), .BUSY_FLAG_O(busy),
		.OVERRUN_FLAG_O(overrun_flag), .TX_DMA_REQ_O(txrq), .RX_DMA_REQ_O(rxrq));
	dma_ctrl_model u_dma (.clk_i(clk), .tx_req_i(txrq), .rx_req_i(rxrq),
		.slow_i(slow), .tx_ack_o(txack), .rx_ack_o(rxack),
		.tx_data_o(txd), .tx_cnt_o(ntx), .rx_cnt_o(nrx));
////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Mode bits settle before enable; link start needs a few link edges
	task mode(input logic [3:0] m);
		{mst, bidir_mode_bit, bidir_output_enable, ronly} = m;
		cyc(2);
		en = 1;
		cyc(12);
	endtask
	task t_write;
		mode(4'b1000);
		wr = 1;
		cyc(1);
		wr = 0;
		`CHK({tx_empty_flag, busy}, 2'b00)
		cyc(1);
		`CHK(busy, 1'b1)
		`WAIT(rx_not_empty_flag, 1'b1)
		`WAIT(busy, 1'b0)
		`CHK({rx_not_empty_flag, tx_empty_flag, busy}, 3'b110)
		`CHK({rxd, sdoe}, {8'hC3, 1'b0})
		rd = 1;
		cyc(1);
		{rd, en} = 2'b00;
		cyc(1);
		`CHK({rx_not_empty_flag, ena}, 2'b00)
		$display("test write done");
	endtask
	task t_dma;
		mode(4'b1000);
		txen = 1;
		`WAIT(ntx, 8'h03)
		txen = 0;
		`WAIT(tx_empty_flag, 1'b1)
		`WAIT(busy, 1'b0)
		`CHK({ntx, tx_empty_flag, busy, overrun_flag, rxrq}, 12'h03A)
		`CHK(rxd, 8'hA1)
		{oclr, rd} = 2'b11;
		cyc(1);
		{oclr, rd, en} = 3'b000;
		`CHK({overrun_flag, rx_not_empty_flag}, 2'b00)
		cyc(2);
		$display("test dma transmit done");
	endtask
	task t_rx(input logic [3:0] m, input logic busy_flag);
		logic [7:0] n0;
		n0 = nrx;
		{rxen, slow} = 2'b11;
		mode(m);
		for (int i = 0; i < 200; i++) begin
			cyc(1);
			`CHK(busy, busy_flag)
		end
		`CHK(nrx - n0 > 8'h01, 1'b1)
		n0 = nrx + 8'h01;
		`WAIT(nrx, n0)
		cyc(7);
		en = 0;
		`WAIT(nrx, n0 + 8'h01)
		cyc(150);
		`CHK({nrx, ena}, {n0 + 8'h01, 1'b0})
		{rxen, slow} = 2'b00;
		$display("test receive %b done", m);
	endtask
	task t_slave;
		rxen = 1;
		mode(4'b0001);
		sel_n = 0;
		`WAIT(busy, 1'b1)
		`WAIT(busy, 1'b0)
		`CHK(busy, 1'b0)
		`WAIT(busy, 1'b1)
		`CHK(k > 5 && k < 17, 1'b1)
		cyc(9);
		en = 0;
		cyc(2);
		`CHK({ena, busy}, 2'b11)
		`WAIT(ena, 1'b0)
		cyc(4);
		`CHK({ena, busy}, 2'b00)
		sel_n = 1;
		$display("test slave receive done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(20);
		rst_n = 1;
		cyc(4);
		`CHK({tx_empty_flag, rx_not_empty_flag, busy, overrun_flag, txrq, rxrq, ena}, 7'h40)
		t_write;
		t_dma;
		t_rx(4'b1001, 1'b1);
		t_rx(4'b1100, 1'b0);
		t_slave;
		final_report;
	end
	initial begin
		#200_000;
		num_errors++;
		final_report;
	end
endmodule
